// [rtl/edge_detect.v]
// rising/falling edge pulse from a synchronised level
// assumes input already on ref_clk
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
    input wire ref_clk,
    input wire sys_rst,
    input wire level_in,
    output wire rise,
    output wire fall
);
    reg prev_q;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level_in;
        end
    end
    assign rise = level_in & ~prev_q;
    assign fall = ~level_in & prev_q;
endmodule // edge_detect
`default_nettype wire

// [rtl/level_sync.v]
// two-flop synchroniser for one asynchronous level
// assumes input comes from a pin or analog comparator
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    input wire ref_clk,
    input wire sys_rst,
    input wire async_in,
    output reg sync_out
);
    reg meta_q;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // level_sync
`default_nettype wire

// [rtl/low_power_mode_and_supply_supervisor.v]
// low-power mode sequencer with supply supervisors and detector
// assumes core requests on ref_clk; supply flags come from analog
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_map.vh"
module low_power_mode_and_supply_supervisor #(
    parameter SETTLE_CYC = `REG_SETTLE_CYC
) (
    input wire ref_clk,
    input wire sys_rst,
    // core side, same clock
    input wire sleep_request,
    input wire [1:0] mode_select,
    input wire stop_low_power_regulator,
    input wire [`EVENT_LINES-1:0] event_lines,
    input wire [`EVENT_LINES-1:0] event_mask,
    input wire rc_request_cec,
    input wire rc_request_first_serial_port,
    input wire rc_request_two_wire_port,
    input wire rtc_event,
    input wire independent_watchdog_reset,
    // asynchronous pins and comparators
    input wire external_reset_pin_n,
    input wire wakeup_pin,
    input wire main_supply_ok,
    input wire analog_supply_ok,
    input wire analog_monitor_disable,
    input wire detector_enable,
    input wire detector_on_fall,
    input wire detector_on_rise,
    input wire detector_above,
    input wire secondary_io_supply_ok,
    // outputs
    output reg core_clock_en,
    output reg core_domain_clock_en,
    output reg pll_en,
    output reg internal_rc_oscillator_en,
    output reg external_crystal_oscillator_en,
    output reg regulator_on,
    output reg regulator_main_mode,
    output reg regulator_low_power_mode,
    output reg rc_clock_grant,
    output reg rtc_watchdog_clocks_en,
    output reg supervisor_reset,
    output reg programmable_supply_detector_irq,
    output reg secondary_io_enable,
    output reg io2_event_line,
    output reg [1:0] active_mode
);
    localparam S_RUN = 5'b00001;
    localparam S_SLEEP = 5'b00010;
    localparam S_STOP = 5'b00100;
    localparam S_STBY = 5'b01000;
    localparam S_RESTORE = 5'b10000;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [11:0] settle_q;
    reg stop_lp_q;
    wire rst_pin_n_s;
    wire wake_s;
    wire vdd_s;
    wire vdda_s;
    wire det_low_s;
    wire io2_s;
    wire wake_rise;
    wire det_rise;
    wire det_fall;

    level_sync u_sync_rst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(external_reset_pin_n), .sync_out(rst_pin_n_s));
    level_sync u_sync_wake (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(wakeup_pin), .sync_out(wake_s));
    level_sync u_sync_vdd (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(main_supply_ok), .sync_out(vdd_s));
    level_sync u_sync_vdda (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(analog_supply_ok), .sync_out(vdda_s));
    // synced inverted so the reset value matches the idle level: no false edge
    level_sync u_sync_det (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(~detector_above), .sync_out(det_low_s));
    level_sync u_sync_io2 (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(secondary_io_supply_ok), .sync_out(io2_s));
    edge_detect u_edge_wake (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(wake_s), .rise(wake_rise), .fall());
    edge_detect u_edge_det (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(det_low_s), .rise(det_fall), .fall(det_rise));

    // line 31 carries the io rail comparator, not the core
    wire [`EVENT_LINES-1:0] lines_all = {~io2_s, event_lines[`EVENT_LINES-2:0]};
    wire any_event = |(lines_all & ~event_mask);
    wire rc_req = rc_request_cec | rc_request_first_serial_port | rc_request_two_wire_port;
    wire supply_bad = ~vdd_s | (~vdda_s & ~analog_monitor_disable);
    wire stby_exit = ~rst_pin_n_s | independent_watchdog_reset | wake_rise | rtc_event;

    always @* begin
        state_d = state_q;
        case (state_q)
            S_RUN: begin
                // core picks mode before the request
                if (sleep_request) begin
                    if (mode_select == `MODE_STOP)
                        state_d = S_STOP;
                    else if (mode_select == `MODE_STANDBY)
                        state_d = S_STBY;
                    else
                        state_d = S_SLEEP;
                end
            end
            S_SLEEP: begin
                if (any_event | rtc_event)
                    state_d = S_RUN;
            end
            S_STOP: begin
                // any unmasked line wakes from stop
                if (any_event)
                    state_d = S_RUN;
                // restore main regulator before rc clock
                else if (rc_req & stop_lp_q)
                    state_d = S_RESTORE;
            end
            S_RESTORE: begin
                if (any_event)
                    state_d = S_RUN;
                else if (!rc_req)
                    state_d = S_STOP;
            end
            S_STBY: begin
                if (stby_exit)
                    state_d = S_RUN;
            end
            default: state_d = S_RUN;
        endcase
    end

    always @(posedge ref_clk) begin
        if (sys_rst | supply_bad) begin
            state_q <= S_RUN;
            stop_lp_q <= 1'b0;
            settle_q <= 12'h000;
        end else begin
            state_q <= state_d;
            if (state_q == S_RUN && state_d == S_STOP)
                stop_lp_q <= stop_low_power_regulator;
            if (state_q == S_RESTORE) begin
                if (settle_q != SETTLE_CYC[11:0])
                    settle_q <= settle_q + 12'h001;
            end else begin
                settle_q <= 12'h000;
            end
        end
    end

    wire in_stop = (state_q == S_STOP) | (state_q == S_RESTORE);
    wire in_stby = (state_q == S_STBY);
    wire settled = (state_q == S_RESTORE) && (settle_q == SETTLE_CYC[11:0]);

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            // regulator on in main mode after reset
            core_clock_en <= 1'b1;
            core_domain_clock_en <= 1'b1;
            pll_en <= 1'b1;
            internal_rc_oscillator_en <= 1'b1;
            external_crystal_oscillator_en <= 1'b1;
            regulator_on <= 1'b1;
            regulator_main_mode <= 1'b1;
            regulator_low_power_mode <= 1'b0;
            rc_clock_grant <= 1'b0;
            rtc_watchdog_clocks_en <= 1'b1;
            supervisor_reset <= 1'b1;
            programmable_supply_detector_irq <= 1'b0;
            secondary_io_enable <= 1'b0;
            io2_event_line <= 1'b0;
            active_mode <= `MODE_SLEEP;
        end else begin
            core_clock_en <= (state_q == S_RUN);
            // stop and standby gate domain, pll, oscillators
            core_domain_clock_en <= ~(in_stop | in_stby);
            pll_en <= ~(in_stop | in_stby);
            external_crystal_oscillator_en <= ~(in_stop | in_stby);
            // rc only once regulator is back in main mode
            internal_rc_oscillator_en <= ~(in_stop | in_stby) | settled
                | ((state_q == S_STOP) & rc_req & ~stop_lp_q);
            rc_clock_grant <= settled | ((state_q == S_STOP) & rc_req & ~stop_lp_q);
            regulator_on <= ~in_stby;
            regulator_low_power_mode <= (state_q == S_STOP) & stop_lp_q;
            regulator_main_mode <= ~in_stby & ~((state_q == S_STOP) & stop_lp_q);
            rtc_watchdog_clocks_en <= 1'b1;
            // hold reset while supply below threshold
            supervisor_reset <= supply_bad;
            programmable_supply_detector_irq <= detector_enable &
                ((det_fall & detector_on_fall) | (det_rise & detector_on_rise));
            // low io rail disables its pins, raises line 31
            secondary_io_enable <= io2_s;
            io2_event_line <= lines_all[`IO2_LINE];
            active_mode <= in_stby ? `MODE_STANDBY : (in_stop ? `MODE_STOP : `MODE_SLEEP);
        end
    end
endmodule // low_power_mode_and_supply_supervisor
`default_nettype wire

// [rtl/pwr_seq_map.vh]
// constants for the low-power mode and supply supervisor
// assumes a 10 MHz ref_clk; included by bare name
`ifndef PWR_SEQ_MAP_VH
`define PWR_SEQ_MAP_VH
`define MODE_SLEEP 2'h0
`define MODE_STOP 2'h1
`define MODE_STANDBY 2'h2
`define REG_SETTLE_NS 2000
`define CLK_PERIOD_NS 100
`define REG_SETTLE_CYC ((`REG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IO2_LINE 31
`define EVENT_LINES 32
`endif

// [tb/core_model.sv]
// processor core model: selects a mode, then requests entry
// assumes the bench drives go and mode by non-blocking at the falling edge
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [1:0] mode,
    input wire logic lp,
    output logic sleep_request = 1'b0,
    output logic [1:0] mode_select = 2'h0,
    output logic stop_low_power_regulator = 1'b0
);
    // mode and regulator settle before request
    always @(negedge ref_clk) begin
        mode_select <= mode;
        stop_low_power_regulator <= lp;
        sleep_request <= go && (mode_select == mode);
    end
endmodule // core_model
`default_nettype wire

// [tb/low_power_mode_and_supply_supervisor_bench.sv]
// self-checking bench for the low-power sequencer
// assumes the core model drives the request side
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_and_supply_supervisor_bench;
    logic ref_clk = 1'b0, sys_rst = 1'b1, go = 1'b0, lp = 1'b0, d_fall = 1'b1;
    logic [2:0] rcr = 3'h0;
    logic [1:0] mode = 2'h0, msel;
    logic [3:0] cause = 4'h0;
    logic [31:0] ev = 32'h0, msk = 32'h0;
    logic m_ok = 1'b1, a_ok = 1'b1, a_dis = 1'b0, d_en = 1'b0, d_rise = 1'b0, d_abv = 1'b1;
    logic io_ok = 1'b1, sreq, slp;
    logic ce, cde, pll, rco, xo, ron, rmm, rlp, grant, rtcw, srst, irq, ioen, io2;
    logic [1:0] am;
    int n_errors = 0, n_tests = 0, n_irq = 0, k;
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) n_irq <= n_irq + irq;
    core_model core_model_inst (.ref_clk(ref_clk), .go(go), .mode(mode), .lp(lp),
        .sleep_request(sreq), .mode_select(msel), .stop_low_power_regulator(slp));
    low_power_mode_and_supply_supervisor #(.SETTLE_CYC(2)) low_power_mode_and_supply_supervisor_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sleep_request(sreq), .mode_select(msel),
        .stop_low_power_regulator(slp), .event_lines(ev), .event_mask(msk),
        .rc_request_cec(rcr[0]), .rc_request_first_serial_port(rcr[1]),
        .rc_request_two_wire_port(rcr[2]), .rtc_event(cause[3]),
        .independent_watchdog_reset(cause[1]), .external_reset_pin_n(~cause[0]),
        .wakeup_pin(cause[2]), .main_supply_ok(m_ok), .analog_supply_ok(a_ok),
        .analog_monitor_disable(a_dis), .detector_enable(d_en), .detector_on_fall(d_fall),
        .detector_on_rise(d_rise), .detector_above(d_abv), .secondary_io_supply_ok(io_ok),
        .core_clock_en(ce), .core_domain_clock_en(cde), .pll_en(pll),
        .internal_rc_oscillator_en(rco), .external_crystal_oscillator_en(xo),
        .regulator_on(ron), .regulator_main_mode(rmm), .regulator_low_power_mode(rlp),
        .rc_clock_grant(grant), .rtc_watchdog_clocks_en(rtcw), .supervisor_reset(srst),
        .programmable_supply_detector_irq(irq), .secondary_io_enable(ioen),
        .io2_event_line(io2), .active_mode(am));
    task automatic cyc(input int n); repeat (n) @(negedge ref_clk); endtask
    task automatic chk(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic req(input logic [1:0] m);
        @(negedge ref_clk) begin mode <= m; go <= 1'b1; end
        cyc(1);
        @(negedge ref_clk) go <= 1'b0;
        cyc(3);
    endtask
    task automatic t_sleep;
        req(2'h0);
        chk("core_clk", 1'b0, ce);
        chk("pll", 1'b1, pll);
        msk = 32'h8; ev[3] = 1'b1; cyc(3);
        chk("masked", 1'b0, ce);
        ev[3] = 1'b0; msk = 32'h0;
        cause = 4'h8; cyc(1); cause = 4'h0; cyc(3);
        chk("core_clk", 1'b1, ce);
    endtask
    task automatic t_stop;
        lp = 1'b1; req(2'h1);
        chk("pll", 1'b0, pll | xo | cde);
        chk("reg_lp", 1'b1, rlp);
        rcr = 3'h5; cyc(3);
        chk("reg_main", 1'b1, rmm);
        chk("grant", 1'b0, grant);
        cyc(3);
        chk("grant", 1'b1, grant);
        chk("rc_osc", 1'b1, rco);
        chk("mode_stop", 1'b1, am == 2'h1);
        rcr = 3'h0; ev[3] = 1'b1; cyc(4); ev[3] = 1'b0;
        chk("core_clk", 1'b1, ce);
        lp = 1'b0;
    endtask
    task automatic t_standby;
        for (int i = 0; i < 4; i++) begin
            req(2'h2);
            chk("reg_on", 1'b0, ron);
            chk("rtc_clk", 1'b1, rtcw);
            chk("mode_stby", 1'b1, am == 2'h2);
            cause = 4'h1 << i; cyc(8); cause = 4'h0; cyc(3);
            chk("core_clk", 1'b1, ce);
        end
    endtask
    task automatic t_supply;
        m_ok = 1'b0; cyc(5); chk("sup_rst", 1'b1, srst);
        m_ok = 1'b1; a_dis = 1'b1; a_ok = 1'b0; cyc(6); chk("sup_rst", 1'b0, srst);
        a_dis = 1'b0; cyc(5); chk("sup_rst", 1'b1, srst);
        a_ok = 1'b1; cyc(6);
    endtask
    task automatic t_detect;
        d_en = 1'b1; k = n_irq; d_abv = 1'b0; cyc(6);
        chk("irq_fall", 1'b1, n_irq != k);
        k = n_irq; d_abv = 1'b1; cyc(6);
        chk("irq_rise", 1'b0, n_irq != k);
        d_rise = 1'b1; k = n_irq; d_abv = 1'b0; cyc(3); d_abv = 1'b1; cyc(6);
        chk("irq_both", 1'b1, n_irq > k + 1);
        d_fall = 1'b0; d_rise = 1'b0; k = n_irq; d_abv = 1'b0; cyc(6);
        chk("irq_nofall", 1'b0, n_irq != k);
    endtask
    task automatic tally_and_finish;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cyc(16); sys_rst = 1'b0; cyc(1);
        chk("reg_main", 1'b1, rmm & ron);
        t_sleep; t_stop; t_standby; t_supply; t_detect;
        io_ok = 1'b0; cyc(5);
        chk("io_en", 1'b0, ioen);
        chk("line31", 1'b1, io2);
        tally_and_finish;
    end
    // hang guard, over twenty times the expected run
    initial begin #400000; n_errors++; tally_and_finish; end
endmodule // low_power_mode_and_supply_supervisor_bench
`default_nettype wire

// [tb/lpm_asserts.sv]
// timing checks on the low-power sequencer ports
// assumes one ref_clk domain and synchronous sys_rst
`timescale 1ns/1ps
`default_nettype none
module lpm_asserts #(parameter SETTLE_CYC = 2) (
    input wire ref_clk,
    input wire sys_rst,
    input wire sleep_request,
    input wire [1:0] mode_select,
    input wire core_clock_en,
    input wire core_domain_clock_en,
    input wire pll_en,
    input wire external_crystal_oscillator_en,
    input wire regulator_on,
    input wire regulator_main_mode,
    input wire rc_clock_grant,
    input wire rtc_watchdog_clocks_en,
    input wire supervisor_reset,
    input wire main_supply_ok,
    input wire analog_supply_ok,
    input wire analog_monitor_disable,
    input wire detector_enable,
    input wire detector_on_fall,
    input wire detector_above,
    input wire programmable_supply_detector_irq,
    input wire secondary_io_supply_ok,
    input wire secondary_io_enable,
    input wire io2_event_line
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    stop_clocks_a: assert property (sleep_request && mode_select == 2'h1 && core_clock_en
        |-> ##2 !pll_en && !external_crystal_oscillator_en && !core_domain_clock_en)
        else $error("stop left a clock running");
    standby_off_a: assert property (sleep_request && mode_select == 2'h2 && core_clock_en
        |-> ##2 !regulator_on) else $error("standby kept the regulator on");
    rc_order_a: assert property (rc_clock_grant |-> regulator_main_mode
        && $past(regulator_main_mode, 2)) else $error("rc clock before main regulator");
    rtc_kept_a: assert property (rtc_watchdog_clocks_en)
        else $error("rtc clocks stopped");
    reset_main_a: assert property ($fell(sys_rst) |-> regulator_on && regulator_main_mode)
        else $error("regulator not main after reset");
    supply_hold_a: assert property ($fell(main_supply_ok) |-> ##[2:4] supervisor_reset)
        else $error("low supply not held in reset");
    analog_mon_a: assert property ((!analog_supply_ok && !analog_monitor_disable)[*4]
        |-> supervisor_reset) else $error("analog supply not monitored");
    det_fall_a: assert property (detector_enable && detector_on_fall && $fell(detector_above)
        |-> ##[2:5] programmable_supply_detector_irq) else $error("no falling detector irq");
    io_rail_a: assert property ((!secondary_io_supply_ok)[*4]
        |-> !secondary_io_enable && io2_event_line) else $error("low io rail still enabled");
    stop_c: cover property (sleep_request && mode_select == 2'h1 && core_clock_en);
    grant_c: cover property ($rose(rc_clock_grant));
    irq_c: cover property (programmable_supply_detector_irq);
endmodule // lpm_asserts
bind low_power_mode_and_supply_supervisor lpm_asserts #(.SETTLE_CYC(SETTLE_CYC)) lpm_asserts_inst (.*);
`default_nettype wire
